// ==== home_seq_pkg.sv ====
// Package with register map, field layout and timing constants for homing
package home_seq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SPEED1_OFS    = 8'h04;
  localparam logic [7:0] SPEED2_OFS    = 8'h08;
  localparam logic [7:0] STANDOFF_OFS  = 8'h0c;
  localparam logic [7:0] HALFTURN_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam logic [7:0] POSITION_OFS  = 8'h18;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT    = 0;
  localparam int CTRL_DIR1_BIT     = 1;
  localparam int CTRL_DIR2_BIT     = 2;
  localparam int CTRL_SRC1_LSB     = 3;
  localparam int CTRL_SRC2_LSB     = 5;
  localparam int CTRL_PHASE2_BIT   = 7;
  localparam int CTRL_BLIND_BIT    = 8;
  localparam int CTRL_FAST_BIT     = 9;
  localparam int CTRL_ABORT_BIT    = 10;
  localparam int CTRL_WIDTH        = 10;

  // Stop source encodings
  localparam logic [1:0] SRC_LIMIT = 2'h0;
  localparam logic [1:0] SRC_REV   = 2'h1;
  localparam logic [1:0] SRC_SYNC  = 2'h2;

  // Reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET     = 10'h000;
  localparam logic [15:0]           SPEED_RESET    = 16'h0000;
  localparam logic [31:0]           STANDOFF_RESET = 32'h0000_0000;
  localparam logic [31:0]           HALFTURN_RESET = 32'h0000_0064;

  // Step pulse divider: steps are spaced by the speed value plus one clocks
  localparam int SPEED_WIDTH = 16;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PHASE1,
    ST_PHASE2,
    ST_STANDOFF,
    ST_DONE
  } home_state_type;

endpackage : home_seq_pkg

// ==== step_gen.sv ====
// Step pulse generator: one step every (period+1) clocks while running
`timescale 1ns/1ps
module step_gen
  import home_seq_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   run_in,
  input  wire logic [SPEED_WIDTH-1:0] period_in,
  output logic                        step_out
);

  logic [SPEED_WIDTH-1:0] count_r;

  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      count_r  <= '0;
      step_out <= 1'b0;
    end else if (count_r >= period_in) begin
      count_r  <= '0;
      step_out <= 1'b1;
    end else begin
      count_r  <= count_r + 1'b1;
      step_out <= 1'b0;
    end
  end

endmodule : step_gen

// ==== home_position_sequencer.sv ====
// Home position calibration sequencer with APB register access
//
// Summary of operation
// - Each search phase moves in its own configured direction, right or left.
// - First-move speed drives standard phase one and fast phase two.
// - Second-move speed drives the second phase of standard homing.
// - Phase one ends on the selected stop: limit, revolution or sync.
// - Phase two has its own stop source selection.
// - Standard second phase runs only when its enable flag is set.
// - Blanking flag ignores phase two stop for half a motor turn.
// - After reference point, move the standoff distance away from it.
// - Standoff sign picks direction: positive right, negative left.
// - Fast flag runs the fast algorithm instead of the standard one.
`timescale 1ns/1ps
module home_position_sequencer
  import home_seq_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        LIMIT_LEFT_IN,
  input  wire logic        LIMIT_RIGHT_IN,
  input  wire logic        REV_SENSOR_IN,
  input  wire logic        SYNC_PULSE_IN,
  output logic             STEP_OUT,
  output logic             DIR_RIGHT_OUT,
  output logic             BUSY_OUT,
  output logic             DONE_OUT
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic [3:0] pin_prev_r;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
      pin_prev_r <= 4'h0;
    end else begin
      pin_meta_r <= {SYNC_PULSE_IN, REV_SENSOR_IN,
                     LIMIT_RIGHT_IN, LIMIT_LEFT_IN};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // Rising edges only, so a sensor already active at start cannot end a
  // phase at once; limits count as a level in the direction of travel.
  logic rev_edge;
  logic sync_edge;
  assign rev_edge  = pin_sync_r[2] & ~pin_prev_r[2];
  assign sync_edge = pin_sync_r[3] & ~pin_prev_r[3];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CTRL_WIDTH-1:0]  ctrl_r;
  logic [SPEED_WIDTH-1:0] speed1_r;
  logic [SPEED_WIDTH-1:0] speed2_r;
  logic [31:0]            standoff_r;
  logic [31:0]            halfturn_r;
  logic                   start_pulse_r;
  logic                   abort_pulse_r;

  logic apb_wr;
  logic apb_rd;
  // Writes land on the completing edge only, so a command bit fires once
  assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
  assign apb_rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;

  function automatic logic addr_known(input logic [7:0] a);
    return (a == CTRL_OFS) || (a == SPEED1_OFS) || (a == SPEED2_OFS) ||
           (a == STANDOFF_OFS) || (a == HALFTURN_OFS) ||
           (a == STATUS_OFS) || (a == POSITION_OFS);
  endfunction : addr_known

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      ctrl_r     <= CTRL_RESET;
      speed1_r   <= SPEED_RESET;
      speed2_r   <= SPEED_RESET;
      standoff_r <= STANDOFF_RESET;
      halfturn_r <= HALFTURN_RESET;
    end else if (apb_wr) begin
      case (PADDR_IN)
        CTRL_OFS:     ctrl_r     <= PWDATA_IN[CTRL_WIDTH-1:0];
        SPEED1_OFS:   speed1_r   <= PWDATA_IN[SPEED_WIDTH-1:0];
        SPEED2_OFS:   speed2_r   <= PWDATA_IN[SPEED_WIDTH-1:0];
        STANDOFF_OFS: standoff_r <= PWDATA_IN;
        HALFTURN_OFS: halfturn_r <= PWDATA_IN;
        default: ;
      endcase
    end
  end

  // Start and abort fire one-cycle command pulses; the start bit also stays set in ctrl_r
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      start_pulse_r <= 1'b0;
      abort_pulse_r <= 1'b0;
    end else begin
      start_pulse_r <= apb_wr && PADDR_IN == CTRL_OFS &&
                       PWDATA_IN[CTRL_START_BIT];
      abort_pulse_r <= apb_wr && PADDR_IN == CTRL_OFS &&
                       PWDATA_IN[CTRL_ABORT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  home_state_type state_r;
  home_state_type state_nxt;
  logic [31:0]    dist_r;
  logic [31:0]    position_r;
  logic           dir_r;
  logic           done_r;
  logic           step_pulse;
  logic           run;
  logic           stop_hit;
  logic [1:0]     src_sel;
  logic           blank;

  logic fast;
  logic use_phase2;
  assign fast       = ctrl_r[CTRL_FAST_BIT];
  assign use_phase2 = ctrl_r[CTRL_PHASE2_BIT] | fast;

  function automatic logic stop_of(input logic [1:0] src,
                                   input logic       right,
                                   input logic [3:0] pins,
                                   input logic       rev_e,
                                   input logic       sync_e);
    case (src)
      SRC_LIMIT: return right ? pins[1] : pins[0];
      SRC_REV:   return rev_e;
      SRC_SYNC:  return sync_e;
      default:   return 1'b0;
    endcase
  endfunction : stop_of

  assign src_sel  = (state_r == ST_PHASE1) ?
                    ctrl_r[CTRL_SRC1_LSB +: 2] :
                    ctrl_r[CTRL_SRC2_LSB +: 2];
  assign blank    = (state_r == ST_PHASE2) && ctrl_r[CTRL_BLIND_BIT] &&
                    (dist_r < halfturn_r);
  // Stop inputs count only while searching; a sensor passed during the
  // standoff move must not stall the step divider.
  logic searching;
  assign searching = (state_r == ST_PHASE1) || (state_r == ST_PHASE2);
  assign stop_hit = searching && !blank &&
                    stop_of(src_sel, dir_r, pin_sync_r,
                            rev_edge, sync_edge);
  assign run      = (state_r == ST_PHASE1) || (state_r == ST_PHASE2) ||
                    (state_r == ST_STANDOFF);

  // Fast homing: phase one uses the second speed for a coarse search, the
  // second phase uses the first speed; standard runs the other way round.
  logic [SPEED_WIDTH-1:0] period;
  always_comb begin
    case (state_r)
      ST_PHASE1: period = fast ? speed2_r : speed1_r;
      ST_PHASE2: period = fast ? speed1_r : speed2_r;
      default:   period = speed1_r;
    endcase
  end

  // Stopping resets the divider, so no stale step leaks into the next phase
  step_gen u_step_gen (
    .clk_in    (CLOCK_IN),
    .rst_in    (RESET_IN),
    .run_in    (run && !stop_hit),
    .period_in (period),
    .step_out  (step_pulse)
  );

  logic [31:0] standoff_mag;
  assign standoff_mag = standoff_r[31] ? (~standoff_r + 32'h1) : standoff_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_pulse_r) state_nxt = ST_PHASE1;
      end
      ST_PHASE1: begin
        if (stop_hit) state_nxt = use_phase2 ? ST_PHASE2 : ST_STANDOFF;
      end
      ST_PHASE2: begin
        if (stop_hit) state_nxt = ST_STANDOFF;
      end
      ST_STANDOFF: begin
        if (dist_r >= standoff_mag) state_nxt = ST_DONE;
      end
      ST_DONE: begin
        if (start_pulse_r) state_nxt = ST_PHASE1;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (abort_pulse_r) state_nxt = ST_IDLE;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) state_r <= ST_IDLE;
    else          state_r <= state_nxt;
  end

  // Distance travelled within the current phase
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || state_nxt != state_r) dist_r <= 32'h0;
    else if (step_pulse && run)           dist_r <= dist_r + 32'h1;
  end

  // Direction for the phase being entered
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      dir_r <= 1'b0;
    end else if (state_nxt != state_r) begin
      case (state_nxt)
        ST_PHASE1:   dir_r <= ctrl_r[CTRL_DIR1_BIT];
        ST_PHASE2:   dir_r <= ctrl_r[CTRL_DIR2_BIT];
        ST_STANDOFF: dir_r <= ~standoff_r[31];
        default:     dir_r <= dir_r;
      endcase
    end
  end

  // Position tracks steps; zeroed at the reference, so the standoff end
  // is the home position measured from the reference point.
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      position_r <= 32'h0;
    end else if (state_r != ST_STANDOFF && state_nxt == ST_STANDOFF) begin
      position_r <= 32'h0;
    end else if (step_pulse && run) begin
      position_r <= dir_r ? position_r + 32'h1 : position_r - 32'h1;
    end
  end

  // Done flag: set wins over a new start in the same cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN)                   done_r <= 1'b0;
    else if (state_nxt == ST_DONE)  done_r <= 1'b1;
    else if (start_pulse_r)         done_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Outputs and read path
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      STEP_OUT      <= 1'b0;
      DIR_RIGHT_OUT <= 1'b0;
      BUSY_OUT      <= 1'b0;
      DONE_OUT      <= 1'b0;
    end else begin
      STEP_OUT      <= step_pulse && run;
      DIR_RIGHT_OUT <= dir_r;
      BUSY_OUT      <= run;
      DONE_OUT      <= done_r;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT  <= 32'h0;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      // One wait state: ready rises in the second access cycle
      PREADY_OUT  <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT &&
                     !addr_known(PADDR_IN);
      PRDATA_OUT  <= 32'h0;
      if (apb_rd && !PREADY_OUT) begin
        case (PADDR_IN)
          CTRL_OFS:     PRDATA_OUT <= {22'h0, ctrl_r};
          SPEED1_OFS:   PRDATA_OUT <= {16'h0, speed1_r};
          SPEED2_OFS:   PRDATA_OUT <= {16'h0, speed2_r};
          STANDOFF_OFS: PRDATA_OUT <= standoff_r;
          HALFTURN_OFS: PRDATA_OUT <= halfturn_r;
          STATUS_OFS:   PRDATA_OUT <= {27'h0, done_r, run, 3'(state_r)};
          POSITION_OFS: PRDATA_OUT <= position_r;
          default:      PRDATA_OUT <= 32'h0;
        endcase
      end
    end
  end

endmodule : home_position_sequencer

// ==== home_seq_monitor.sv ====
// Port checker for the homing sequencer
`timescale 1ns/1ps
module home_seq_monitor (
  input wire logic        CLOCK_IN,
  input wire logic        RESET_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        STEP_OUT,
  input wire logic        DIR_RIGHT_OUT,
  input wire logic        BUSY_OUT,
  input wire logic        DONE_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);

  a_step_when_busy: assert property (STEP_OUT |-> BUSY_OUT)
    else $error("step seen while not moving");
  a_dir_steady: assert property (STEP_OUT |-> $stable(DIR_RIGHT_OUT))
    else $error("direction changed under a step");
  a_done_means_idle: assert property (DONE_OUT |-> !BUSY_OUT)
    else $error("done and busy together");
  a_done_after_move: assert property ($rose(DONE_OUT) |-> $past(BUSY_OUT))
    else $error("done rose without a move before it");
  a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held longer than one cycle");
  a_ready_wait_state: assert property
    (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready missing after the wait state");
  a_error_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("slave error without ready");
  a_error_data_zero: assert property (PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("nonzero read data on error");
  a_reset_quiet: assert property
    ($fell(RESET_IN) |-> !BUSY_OUT && !DONE_OUT && !STEP_OUT && !PREADY_OUT)
    else $error("outputs active after reset");
endmodule : home_seq_monitor

bind home_position_sequencer home_seq_monitor mon (.CLOCK_IN, .RESET_IN,
  .PSEL_IN, .PENABLE_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .STEP_OUT,
  .BUSY_OUT, .DONE_OUT, .DIR_RIGHT_OUT);

// ==== motor_model.sv ====
// Motor stand-in: step position, end switches, revolution sensor
`timescale 1ns/1ps
module motor_model #(
  parameter int LW = 20
) (
  input  wire logic clk_in,
  input  wire logic step_in,
  input  wire logic right_in,
  output logic      left_out,
  output logic      right_out,
  output logic      rev_out
);
  int   pos = 0;
  int   cyc = 0;
  int   t0 = 0;
  int   n = 0;
  int   gaps[$];
  logic lr = 1'b0;

  // Switches close at the travel ends; the sensor marks every eighth step
  assign left_out  = (pos <= -LW);
  assign right_out = (pos >= LW);
  assign rev_out   = ((pos % 8) == 0);

  // First gap of each run in one direction gives the step period used
  always @(posedge clk_in) begin
    cyc++;
    if (step_in === 1'b1) begin
      pos = right_in ? pos + 1 : pos - 1;
      if (n == 0 || right_in !== lr) begin
        n = 1;
        t0 = cyc;
        lr = right_in;
      end else if (n == 1) begin
        gaps.push_back(cyc - t0);
        n = 2;
      end
    end
  end
endmodule : motor_model

// ==== tb_top.sv ====
// Self-checking bench: register access and homing runs on a motor stand-in
`timescale 1ns/1ps
module tb_top;
  import home_seq_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        sync = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic        prdy, perr, stp, dir, busy, done, lim_l, lim_r, rev;
  logic [32:0] exp_q[$];
  int          errors = 0;
  int          checks = 0;
  int          so;

  initial forever #2.5 clk = ~clk;

  home_position_sequencer dut (.CLOCK_IN(clk), .RESET_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(addr),
    .PWDATA_IN(wd), .PRDATA_OUT(rd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .LIMIT_LEFT_IN(lim_l), .LIMIT_RIGHT_IN(lim_r), .REV_SENSOR_IN(rev),
    .SYNC_PULSE_IN(sync), .STEP_OUT(stp), .DIR_RIGHT_OUT(dir),
    .BUSY_OUT(busy), .DONE_OUT(done));
  motor_model mot (.clk_in(clk), .step_in(stp), .right_in(dir),
    .left_out(lim_l), .right_out(lim_r), .rev_out(rev));

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic fail(input string w);
    errors++;
    $display("CHECK FAILED %s expected 1 seen 0", w);
    close_out();
  endtask : fail

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED read expected %h seen %h", e, s);
    end
  endtask : cmp_rd

  task automatic cmp_mot(input string w, input int e, input int s);
    checks++;
    if (s != e) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", w, e, s);
    end
  endtask : cmp_mot

  // Read results are matched against the oldest note in the queue
  always @(posedge clk) begin
    if (psel && pen && prdy === 1'b1 && !pwr) cmp_rd(exp_q.pop_front(),
      {perr, rd});
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 40);
    psel <= 1'b0;
    pen  <= 1'b0;
    if (k >= 40) fail("ready");
  endtask : xfer

  task automatic rdc(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rdc

  task automatic wt(input bit d);
    int k;
    k = 0;
    while ((d ? done : busy) !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000) fail("wait");
  endtask : wt

  // One homing run; a nonzero sy fires the sync pulse at that motor position
  task automatic home(input string nm, input logic [31:0] c, input int s,
                      input int sy, input int fin, input int g0, input int g1);
    int k;
    k = 0;
    mot.pos = 0;
    mot.n = 0;
    mot.gaps.delete();
    xfer(1'b1, STANDOFF_OFS, 32'(s));
    xfer(1'b1, CTRL_OFS, c);
    wt(1'b0);
    if (sy != 0) begin
      while (mot.pos != sy && k < 500) begin
        @(posedge clk);
        k++;
      end
      if (k >= 500) fail("sync");
      sync <= 1'b1;
      repeat (4) @(posedge clk);
      sync <= 1'b0;
    end
    wt(1'b1);
    rdc(STATUS_OFS, 33'h14);
    rdc(POSITION_OFS, {1'b0, 32'(s)});
    cmp_mot("final position", fin, mot.pos);
    cmp_mot("first step gap", g0, mot.gaps[0]);
    if (g1 != 0) cmp_mot("second step gap", g1, mot.gaps[1]);
    $display("test %s finished", nm);
  endtask : home

  // Control words: start, dirs, sources, phase two, blanking, fast
  initial begin
    void'($urandom(56));
    so = 1 + ($urandom % 7);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(CTRL_OFS, 33'h0);
    rdc(SPEED1_OFS, 33'h0);
    rdc(STANDOFF_OFS, 33'h0);
    rdc(HALFTURN_OFS, {1'b0, HALFTURN_RESET});
    rdc(STATUS_OFS, 33'h0);
    rdc(8'h1c, 33'h1_0000_0000);
    $display("test reset values finished");
    xfer(1'b1, SPEED1_OFS, 32'h9);
    xfer(1'b1, SPEED2_OFS, 32'h4);
    xfer(1'b1, HALFTURN_OFS, 32'h6);
    home("limit", 32'h025, so, 0, so - 20, 10, 0);
    home("phase two", 32'h0a5, 3, 0, -13, 10, 5);
    home("blanking", 32'h1a5, 3, 0, -5, 10, 5);
    home("sync", 32'h013, -2, 3, 1, 10, 0);
    home("fast", 32'h22b, 1, 0, 1, 5, 10);
    // Abort in mid search must drop back to idle with nothing reported
    xfer(1'b1, CTRL_OFS, 32'h001);
    wt(1'b0);
    xfer(1'b1, CTRL_OFS, 32'h400);
    rdc(STATUS_OFS, 33'h0);
    $display("test abort finished");
    close_out();
  end
endmodule : tb_top
